// ==== shared/fcs_defs.vh ====
`ifndef FCS_DEFS_VH
`define FCS_DEFS_VH

// Register addresses
`define FCS_ADDR_CTRL        8'h60
`define FCS_ADDR_LIVE        8'h61
`define FCS_ADDR_LATCHED     8'h62
`define FCS_ADDR_IRQ_EN      8'h63
`define FCS_ADDR_TX_CW_A     8'h64
`define FCS_ADDR_TX_CW_B     8'h65
`define FCS_ADDR_RX_CW       8'h66

// Control register fields
`define FCS_CTRL_SEL_LSB     0
`define FCS_CTRL_SEL_MSB     1
`define FCS_CTRL_RX_RESET    2

// Status bit positions (latched and enable share them; live uses bits 0-3, with bit 3 as FIFO empty)
`define FCS_ST_TX_IDLE       0
`define FCS_ST_CODE_DET      1
`define FCS_ST_RX_IDLE       2
`define FCS_ST_FIFO_NE       3
`define FCS_ST_FIFO_OVF      4
`define FCS_ST_WIDTH         5
`define FCS_LIVE_FIFO_EMPTY  3

// Transmit select values
`define FCS_SEL_IDLE         2'h0
`define FCS_SEL_A_ONLY       2'h1
`define FCS_SEL_A_THEN_B     2'h2
`define FCS_SEL_A_CONT       2'h3

// Codeword shape and counts
`define FCS_CW_BITS          6
`define FCS_FRAME_BITS       16
`define FCS_FRAME_LAST       4'hF
`define FCS_FLAG_ONES        8'hFF
`define FCS_REPEAT           4'hA
`define FCS_VALIDATE         2'h3
`define FCS_IDLE_ONES        5'h10
`define FCS_FIFO_DEPTH       4
`define FCS_RESET_ZERO       8'h00

`endif

// ==== rtl/fcs_feac_ctrl.v ====
// How it works
// - Rx idle latch sets on rise, W1C
// - Not-empty latch sets on empty fall, W1C
// - Full FIFO drops codeword, sets overflow latch
// - Overflow latch sets on each overflow, W1C
// - Interrupt drops on master off or when the last enabled term clears
// - Five enables in bits 0-4, reset 0
// - Frame: eight ones, zero, six bits, zero
// - Codeword A bits 0-5, LSB first
// - Codeword B bits 0-5, LSB first
// - Only select field starts transmission
// - Rx register gives six bits, bit0 first
// - Rx idle after 16 ones, cleared on validate
// - Receive FIFO holds four codewords
// - Select 01/10/11/00 sequencing of A and B
`timescale 1ns/100ps
`include "fcs_defs.vh"

module fcs_fifo
#(
  parameter WIDTH = 6,
  parameter DEPTH = 4
)
(
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire             flush_i,
  // Fill side
  input  wire             in_valid_i,
  output wire             in_ready_o,
  input  wire [WIDTH-1:0] in_data_i,
  // Drain side
  output wire             out_valid_o,
  input  wire             out_ready_i,
  output wire [WIDTH-1:0] out_data_o
);
  localparam AW = (DEPTH <= 2) ? 1 : $clog2(DEPTH);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr;
  reg [AW-1:0]    rd_ptr;
  reg [AW:0]      count;
  wire            push;
  wire            pop;

  assign in_ready_o  = (count != DEPTH[AW:0]);
  assign out_valid_o = (count != {(AW+1){1'b0}});
  assign out_data_o  = mem[rd_ptr];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  always @(posedge sys_clk_i)
  begin
    if (push)
      mem[wr_ptr] <= in_data_i;
  end

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else if (flush_i)
    begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : wr_ptr + 1'b1;
      if (pop)
        rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}}
                                                   : rd_ptr + 1'b1;
      if (push & ~pop)
        count <= count + 1'b1;
      else if (pop & ~push)
        count <= count - 1'b1;
    end
  end
endmodule

module fcs_feac_ctrl
(
  // Clock and reset
  input  wire       sys_clk_i,
  input  wire       rst_i,
  // Processor port
  input  wire       cpu_cs_i,
  input  wire       cpu_wr_i,
  input  wire       cpu_rd_i,
  input  wire [7:0] cpu_addr_i,
  input  wire [7:0] cpu_wdata_i,
  output reg  [7:0] cpu_rdata_o,
  // Interrupt
  input  wire       alarm_channel_master_irq_en_i,
  output wire       feac_irq_o,
  // FEAC channel bits from the framer
  input  wire       feac_rx_bit_i,
  input  wire       feac_rx_bit_en_i,
  input  wire       feac_tx_bit_req_i,
  output reg        feac_tx_bit_o
);
  localparam TX_IDLE = 1'b0;
  localparam TX_SEND = 1'b1;

  wire wr_en = cpu_cs_i & cpu_wr_i;
  wire rd_en = cpu_cs_i & cpu_rd_i;

  // Software registers
  reg [1:0]                tx_code_select;
  reg                      rx_reset_bit;
  reg [`FCS_ST_WIDTH-1:0]  feac_irq_enable_reg;
  reg [`FCS_CW_BITS-1:0]   tx_code_a_bits;
  reg [`FCS_CW_BITS-1:0]   tx_code_b_bits;
  reg [`FCS_ST_WIDTH-1:0]  feac_latched_status_reg;

  // Live status and edge history
  wire                     tx_idle_live;
  reg                      rx_code_detect_live;
  reg                      rx_idle_live;
  wire                     rx_fifo_empty_live;
  reg [2:0]                live_q;

  // Receiver
  reg [`FCS_FRAME_BITS-1:0] rx_shift;
  reg [4:0]                 rx_ones_cnt;
  reg [`FCS_CW_BITS-1:0]    rx_cand;
  reg [1:0]                 rx_cand_cnt;
  reg [`FCS_CW_BITS-1:0]    rx_valid_cw;
  reg                       rx_push;
  reg [`FCS_CW_BITS-1:0]    rx_push_data;
  wire                      fifo_in_ready;
  wire                      fifo_out_valid;
  wire [`FCS_CW_BITS-1:0]   rx_code_bits;
  wire                      rx_flush;
  wire                      overflow_evt;
  wire                      rx_pop;

  // Transmitter
  reg                       tx_state;
  reg [1:0]                 tx_mode;
  reg [3:0]                 tx_bit_idx;
  reg [3:0]                 tx_cw_cnt;
  reg                       tx_phase_b;
  reg                       tx_armed;
  wire [`FCS_CW_BITS-1:0]   tx_cw;
  wire [`FCS_FRAME_BITS-1:0] tx_frame;
  wire [3:0]                tx_cw_next;

  // Latch sets and clears
  wire [`FCS_ST_WIDTH-1:0] lat_set;
  wire [`FCS_ST_WIDTH-1:0] lat_clr;
  wire [`FCS_ST_WIDTH-1:0] next_latched;

  // Receive shift and match; newest bit enters at the top
  wire [`FCS_FRAME_BITS-1:0] rx_shift_n = {feac_rx_bit_i, rx_shift[15:1]};
  wire rx_match = (rx_shift_n[7:0] == `FCS_FLAG_ONES) & ~rx_shift_n[8]
                  & ~rx_shift_n[15];
  wire [`FCS_CW_BITS-1:0] rx_data = rx_shift_n[14:9];
  wire rx_same = (rx_data == rx_cand);
  wire rx_validate = feac_rx_bit_en_i & rx_match & rx_same
                     & (rx_cand_cnt == `FCS_VALIDATE - 2'h1)
                     & ~(rx_code_detect_live & (rx_data == rx_valid_cw));

  // Rx reset acts on its rising edge only
  reg rx_reset_q;
  assign rx_flush = rx_reset_bit & ~rx_reset_q;

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rx_shift            <= {`FCS_FRAME_BITS{1'b0}};
      rx_ones_cnt         <= 5'h00;
      rx_cand             <= {`FCS_CW_BITS{1'b0}};
      rx_cand_cnt         <= 2'h0;
      rx_valid_cw         <= {`FCS_CW_BITS{1'b0}};
      rx_code_detect_live <= 1'b0;
      rx_idle_live        <= 1'b0;
      rx_push             <= 1'b0;
      rx_push_data        <= {`FCS_CW_BITS{1'b0}};
      rx_reset_q          <= 1'b0;
    end
    else
    begin
      rx_reset_q <= rx_reset_bit;
      rx_push    <= rx_validate;
      if (rx_validate)
        rx_push_data <= rx_data;
      if (rx_flush)
      begin
        rx_shift            <= {`FCS_FRAME_BITS{1'b0}};
        rx_ones_cnt         <= 5'h00;
        rx_cand_cnt         <= 2'h0;
        rx_code_detect_live <= 1'b0;
        rx_idle_live        <= 1'b0;
      end
      else if (feac_rx_bit_en_i)
      begin
        rx_shift <= rx_shift_n;
        if (!feac_rx_bit_i)
          rx_ones_cnt <= 5'h00;
        else if (rx_ones_cnt != `FCS_IDLE_ONES)
          rx_ones_cnt <= rx_ones_cnt + 5'h01;
        if (feac_rx_bit_i && rx_ones_cnt == `FCS_IDLE_ONES - 5'h01)
          rx_idle_live <= 1'b1;
        if (rx_match)
        begin
          if (!rx_same)
          begin
            rx_cand     <= rx_data;
            rx_cand_cnt <= 2'h1;
          end
          else if (rx_cand_cnt != `FCS_VALIDATE)
            rx_cand_cnt <= rx_cand_cnt + 2'h1;
          // A different codeword seen twice ends the detect
          if (rx_code_detect_live && rx_same && rx_cand_cnt == 2'h1
              && rx_data != rx_valid_cw)
            rx_code_detect_live <= 1'b0;
          if (rx_validate)
          begin
            rx_valid_cw         <= rx_data;
            rx_code_detect_live <= 1'b1;
            rx_idle_live        <= 1'b0;
          end
        end
      end
    end
  end

  // Full FIFO refuses the write; the codeword is dropped
  assign overflow_evt = rx_push & ~fifo_in_ready;
  assign rx_pop = rd_en & (cpu_addr_i == `FCS_ADDR_RX_CW);

  fcs_fifo
  #(
    .WIDTH (`FCS_CW_BITS),
    .DEPTH (`FCS_FIFO_DEPTH)
  )
  u_rx_fifo
  (
    .sys_clk_i   (sys_clk_i),
    .rst_i       (rst_i),
    .flush_i     (rx_flush),
    .in_valid_i  (rx_push),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (rx_push_data),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (rx_pop),
    .out_data_o  (rx_code_bits)
  );

  assign rx_fifo_empty_live = ~fifo_out_valid;

  // Transmit sequencer
  assign tx_idle_live = (tx_state == TX_IDLE);
  assign tx_cw        = tx_phase_b ? tx_code_b_bits : tx_code_a_bits;
  assign tx_frame     = {1'b0, tx_cw, 1'b0, `FCS_FLAG_ONES};
  assign tx_cw_next   = tx_cw_cnt + 4'h1;

  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_state      <= TX_IDLE;
      tx_mode       <= `FCS_SEL_IDLE;
      tx_bit_idx    <= 4'h0;
      tx_cw_cnt     <= 4'h0;
      tx_phase_b    <= 1'b0;
      tx_armed      <= 1'b1;
      feac_tx_bit_o <= 1'b1;
    end
    else
    begin
      // A new action needs the select parked at idle first
      if (tx_code_select == `FCS_SEL_IDLE)
        tx_armed <= 1'b1;
      case (tx_state)
        TX_IDLE:
        begin
          if (feac_tx_bit_req_i)
            feac_tx_bit_o <= 1'b1;
          if (tx_armed && tx_code_select != `FCS_SEL_IDLE)
          begin
            tx_state   <= TX_SEND;
            tx_mode    <= tx_code_select;
            tx_bit_idx <= 4'h0;
            tx_cw_cnt  <= 4'h0;
            tx_phase_b <= 1'b0;
            tx_armed   <= 1'b0;
          end
        end
        TX_SEND:
        begin
          if (feac_tx_bit_req_i)
          begin
            feac_tx_bit_o <= tx_frame[tx_bit_idx];
            tx_bit_idx    <= tx_bit_idx + 4'h1;
            if (tx_bit_idx == `FCS_FRAME_LAST)
            begin
              tx_cw_cnt <= (tx_cw_next > `FCS_REPEAT) ? `FCS_REPEAT
                                                       : tx_cw_next;
              case (tx_mode)
                `FCS_SEL_A_ONLY:
                begin
                  if (tx_cw_next == `FCS_REPEAT)
                    tx_state <= TX_IDLE;
                end
                `FCS_SEL_A_THEN_B:
                begin
                  if (tx_cw_next == `FCS_REPEAT)
                  begin
                    tx_cw_cnt  <= 4'h0;
                    tx_phase_b <= 1'b1;
                    if (tx_phase_b)
                      tx_state <= TX_IDLE;
                  end
                end
                default:
                begin
                  if (tx_code_select == `FCS_SEL_IDLE
                      && tx_cw_next >= `FCS_REPEAT)
                    tx_state <= TX_IDLE;
                end
              endcase
            end
          end
        end
        default:
          tx_state <= TX_IDLE;
      endcase
    end
  end

  // Edge history of the live bits feeding latches
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      live_q <= 3'h5; // tx idle and fifo empty at rest
    else
      live_q <= {rx_fifo_empty_live, rx_idle_live, tx_idle_live};
  end

  assign lat_set[`FCS_ST_TX_IDLE]  = tx_idle_live & ~live_q[0];
  assign lat_set[`FCS_ST_CODE_DET] = rx_validate;
  assign lat_set[`FCS_ST_RX_IDLE]  = rx_idle_live & ~live_q[1];
  assign lat_set[`FCS_ST_FIFO_NE]  = ~rx_fifo_empty_live & live_q[2];
  assign lat_set[`FCS_ST_FIFO_OVF] = overflow_evt;

  assign lat_clr = (wr_en && cpu_addr_i == `FCS_ADDR_LATCHED)
                   ? cpu_wdata_i[`FCS_ST_WIDTH-1:0]
                   : {`FCS_ST_WIDTH{1'b0}};

  // A set in the clearing cycle survives the clear
  assign next_latched = (feac_latched_status_reg & ~lat_clr) | lat_set;

  // Register writes
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      tx_code_select          <= `FCS_SEL_IDLE;
      rx_reset_bit            <= 1'b0;
      feac_irq_enable_reg     <= {`FCS_ST_WIDTH{1'b0}};
      tx_code_a_bits          <= {`FCS_CW_BITS{1'b0}};
      tx_code_b_bits          <= {`FCS_CW_BITS{1'b0}};
      feac_latched_status_reg <= {`FCS_ST_WIDTH{1'b0}};
    end
    else
    begin
      feac_latched_status_reg <= next_latched;
      if (wr_en)
      begin
        case (cpu_addr_i)
          `FCS_ADDR_CTRL:
          begin
            tx_code_select <= cpu_wdata_i[`FCS_CTRL_SEL_MSB:`FCS_CTRL_SEL_LSB];
            rx_reset_bit   <= cpu_wdata_i[`FCS_CTRL_RX_RESET];
          end
          `FCS_ADDR_IRQ_EN:
            feac_irq_enable_reg <= cpu_wdata_i[`FCS_ST_WIDTH-1:0];
          // Rewriting mid-send changes the word on air
          `FCS_ADDR_TX_CW_A:
            tx_code_a_bits <= cpu_wdata_i[`FCS_CW_BITS-1:0];
          `FCS_ADDR_TX_CW_B:
            tx_code_b_bits <= cpu_wdata_i[`FCS_CW_BITS-1:0];
          default:
            tx_code_select <= tx_code_select;
        endcase
      end
    end
  end

  // Register reads, one cycle after the strobe
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cpu_rdata_o <= `FCS_RESET_ZERO;
    else if (rd_en)
    begin
      case (cpu_addr_i)
        `FCS_ADDR_CTRL:
          cpu_rdata_o <= {5'h00, rx_reset_bit, tx_code_select};
        `FCS_ADDR_LIVE:
          cpu_rdata_o <= {4'h0, rx_fifo_empty_live, rx_idle_live,
                          rx_code_detect_live, tx_idle_live};
        `FCS_ADDR_LATCHED:
          cpu_rdata_o <= {3'h0, feac_latched_status_reg};
        `FCS_ADDR_IRQ_EN:
          cpu_rdata_o <= {3'h0, feac_irq_enable_reg};
        `FCS_ADDR_TX_CW_A:
          cpu_rdata_o <= {2'h0, tx_code_a_bits};
        `FCS_ADDR_TX_CW_B:
          cpu_rdata_o <= {2'h0, tx_code_b_bits};
        `FCS_ADDR_RX_CW:
          cpu_rdata_o <= fifo_out_valid ? {2'h0, rx_code_bits}
                                        : `FCS_RESET_ZERO;
        default:
          cpu_rdata_o <= `FCS_RESET_ZERO;
      endcase
    end
  end

  // Combinational, so it drops at once when the last enabled term clears
  assign feac_irq_o = alarm_channel_master_irq_en_i
                      & |(feac_latched_status_reg & feac_irq_enable_reg);
endmodule

// ==== tb/fcs_feac_ctrl_checker.sv ====
`timescale 1ns/100ps
module fcs_feac_ctrl_checker
(
  // Clock and reset
  input wire logic       sys_clk_i,
  input wire logic       rst_i,
  // Processor port
  input wire logic       cpu_cs_i,
  input wire logic       cpu_wr_i,
  input wire logic       cpu_rd_i,
  input wire logic [7:0] cpu_addr_i,
  input wire logic [7:0] cpu_wdata_i,
  input wire logic [7:0] cpu_rdata_o,
  // Interrupt
  input wire logic       alarm_channel_master_irq_en_i,
  input wire logic       feac_irq_o,
  // Channel bits
  input wire logic       feac_rx_bit_i,
  input wire logic       feac_rx_bit_en_i,
  input wire logic       feac_tx_bit_req_i,
  input wire logic       feac_tx_bit_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);

  wire rd_q = cpu_cs_i && cpu_rd_i;

  sequence s_en_wr;
    cpu_cs_i && cpu_wr_i && cpu_addr_i == 8'h63;
  endsequence

  sequence s_en_rd;
    rd_q && cpu_addr_i == 8'h63;
  endsequence

  // Bench leaves one idle cycle between accesses
  AST_EN_READBACK: assert property (
    s_en_wr ##2 s_en_rd |=>
      cpu_rdata_o == {3'h0, $past(cpu_wdata_i[4:0], 3)})
    else $error("enable register readback wrong");
  AST_UNMAPPED: assert property (
    rd_q && (cpu_addr_i < 8'h60 || cpu_addr_i > 8'h66) |=>
      cpu_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  AST_TOP_ZERO: assert property (cpu_rdata_o[7:6] == 2'h0)
    else $error("unused read bits set");
  AST_STATUS_TOP: assert property (
    rd_q && cpu_addr_i inside {8'h61, 8'h62, 8'h63} |=>
      cpu_rdata_o[7:5] == 3'h0)
    else $error("unused status bits set");
  AST_RDATA_HOLD: assert property (!rd_q |=> $stable(cpu_rdata_o))
    else $error("read data moved without a read");
  AST_IRQ_MASTER: assert property (
    !alarm_channel_master_irq_en_i |-> !feac_irq_o)
    else $error("interrupt without master enable");
  AST_IRQ_DISABLE: assert property (
    s_en_wr and cpu_wdata_i[4:0] == 5'h00 |=> !feac_irq_o)
    else $error("interrupt kept after enables cleared");
  AST_TX_ON_REQ: assert property (
    !feac_tx_bit_req_i |=> $stable(feac_tx_bit_o))
    else $error("tx bit moved without request");
endmodule

// ==== tb/fcs_far_end.sv ====
`timescale 1ns/100ps
module fcs_far_end
(
  // Clock
  input  wire logic sys_clk_i,
  // Channel toward the device
  output logic      rx_bit_o,
  output logic      rx_bit_en_o,
  input  wire logic tx_bit_i,
  output logic      tx_req_o
);
  logic [15:0] got [$];

  initial
  begin
    rx_bit_o = 1'b0;
    rx_bit_en_o = 1'b0;
    tx_req_o = 1'b0;
  end

  // Line flips while unqualified so stale bits never look valid
  task send_bits(input logic [15:0] v, input int n, input int gap);
    int i;
    begin
      for (i = 0; i < n; i++)
      begin
        rx_bit_o = v[i];
        rx_bit_en_o = 1'b1;
        @(posedge sys_clk_i);
        #1;
        if (gap > 0)
        begin
          rx_bit_en_o = 1'b0;
          rx_bit_o = ~rx_bit_o;
          repeat (gap) @(posedge sys_clk_i);
          #1;
        end
      end
      rx_bit_en_o = 1'b0;
      rx_bit_o = ~rx_bit_o;
      @(posedge sys_clk_i);
      #1;
    end
  endtask

  task send_word(input logic [5:0] cw, input int frames, input int gap);
    repeat (frames) send_bits({1'b0, cw, 1'b0, 8'hFF}, 16, gap);
  endtask

  task pull(input int n, input int gap);
    logic [15:0] w;
    int i, j;
    begin
      for (j = 0; j < n; j++)
      begin
        for (i = 0; i < 16; i++)
        begin
          tx_req_o = 1'b1;
          @(posedge sys_clk_i);
          #1;
          w[i] = tx_bit_i;
          if (gap > 0)
          begin
            tx_req_o = 1'b0;
            repeat (gap) @(posedge sys_clk_i);
            #1;
          end
        end
        got.push_back(w);
      end
      tx_req_o = 1'b0;
      @(posedge sys_clk_i);
      #1;
    end
  endtask
endmodule

// ==== tb/fcs_feac_ctrl_tb.sv ====
`timescale 1ns/100ps
module fcs_feac_ctrl_tb;
  logic       sys_clk_i = 1'b0;
  logic       rst_i = 1'b1;
  logic       cs = 1'b0;
  logic       we = 1'b0;
  logic       re = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic [7:0] rdat;
  logic       mst = 1'b0;
  logic       irq;
  logic       rxb;
  logic       rxe;
  logic       txr;
  logic       txb;
  int         err_count = 0;
  int         compares = 0;
  int         cyc = 0;

  always #5 sys_clk_i = ~sys_clk_i;

  fcs_feac_ctrl dut_u
  (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_cs_i(cs), .cpu_wr_i(we),
    .cpu_rd_i(re), .cpu_addr_i(addr), .cpu_wdata_i(wd), .cpu_rdata_o(rdat),
    .alarm_channel_master_irq_en_i(mst), .feac_irq_o(irq),
    .feac_rx_bit_i(rxb), .feac_rx_bit_en_i(rxe),
    .feac_tx_bit_req_i(txr), .feac_tx_bit_o(txb)
  );

  fcs_far_end fe_u
  (
    .sys_clk_i(sys_clk_i), .rx_bit_o(rxb), .rx_bit_en_o(rxe),
    .tx_bit_i(txb), .tx_req_o(txr)
  );

  task end_of_test;
    begin
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask

  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      err_count++;
      end_of_test;
    end
  end

  task chk_reg(input logic [7:0] exp, input logic [7:0] act);
    begin
      compares++;
      if (act !== exp)
      begin
        err_count++;
        $display("mismatch t=%0t exp=%h act=%h", $time, exp, act);
      end
    end
  endtask

  task chk_word(input logic [15:0] exp, input logic [15:0] act);
    begin
      compares++;
      if (act !== exp)
      begin
        err_count++;
        $display("mismatch t=%0t exp=%h act=%h", $time, exp, act);
      end
    end
  endtask

  task step;
    begin
      @(posedge sys_clk_i);
      #1;
    end
  endtask

  task wr(input logic [7:0] a, input logic [7:0] d);
    begin
      step;
      cs = 1'b1;
      we = 1'b1;
      addr = a;
      wd = d;
      step;
      cs = 1'b0;
      we = 1'b0;
    end
  endtask

  task rdck(input logic [7:0] a, input logic [7:0] exp);
    begin
      step;
      cs = 1'b1;
      re = 1'b1;
      addr = a;
      step;
      cs = 1'b0;
      re = 1'b0;
      chk_reg(exp, rdat);
    end
  endtask

  task t_regs;
    begin
      rdck(8'h63, 8'h00);
      rdck(8'h64, 8'h00);
      rdck(8'h65, 8'h00);
      rdck(8'h62, 8'h00);
      rdck(8'h61, 8'h09);
      rdck(8'h60, 8'h00);
      wr(8'h63, 8'hFF);
      rdck(8'h63, 8'h1F);
      wr(8'h63, 8'h00);
      wr(8'h64, 8'hED);
      rdck(8'h64, 8'h2D);
      wr(8'h67, 8'hFF);
      rdck(8'h67, 8'h00);
      $display("regs test done");
    end
  endtask

  task t_tx;
    logic [15:0] fa, fb, w;
    int m, k;
    begin
      fa = {1'b0, 6'h2D, 1'b0, 8'hFF};
      fb = {1'b0, 6'h12, 1'b0, 8'hFF};
      wr(8'h65, 8'hD2);
      fe_u.pull(1, 0);
      chk_word(16'hFFFF, fe_u.got.pop_front());
      for (m = 1; m <= 2; m++)
      begin
        wr(8'h60, m[7:0]);
        // Sequencer leaves idle one edge after the write
        step;
        fe_u.pull(m * 10 + 1, m - 1);
        for (k = 0; k < 10 * m; k++)
          chk_word(k < 10 ? fa : fb, fe_u.got.pop_front());
        chk_word(16'hFFFF, fe_u.got.pop_front());
        rdck(8'h62, 8'h01);
        wr(8'h62, 8'h01);
        wr(8'h60, 8'h00);
      end
      wr(8'h60, 8'h03);
      step;
      fe_u.pull(12, 0);
      wr(8'h60, 8'h00);
      fe_u.pull(2, 0);
      for (k = 0; k < 12; k++)
        chk_word(fa, fe_u.got.pop_front());
      // Stop is seen only at a word's end, so one more A goes out
      w = fe_u.got.pop_front();
      chk_word(fa, w);
      chk_word(16'hFFFF, fe_u.got.pop_front());
      $display("tx test done");
    end
  endtask

  task t_rx;
    logic [5:0] cw [0:5];
    int i;
    begin
      cw = '{6'h05, 6'h12, 6'h2B, 6'h30, 6'h07, 6'h19};
      wr(8'h62, 8'h1F);
      fe_u.send_bits(16'hFFFF, 16, 1);
      repeat (3) step;
      rdck(8'h62, 8'h04);
      wr(8'h62, 8'h04);
      fe_u.send_bits(16'hFFFF, 16, 0);
      rdck(8'h62, 8'h00);
      for (i = 0; i < 5; i++)
        fe_u.send_word(cw[i], 3, i % 2);
      repeat (3) step;
      rdck(8'h62, 8'h1A);
      mst = 1'b1;
      step;
      chk_reg(8'h00, {7'h00, irq});
      wr(8'h63, 8'h10);
      chk_reg(8'h01, {7'h00, irq});
      mst = 1'b0;
      step;
      chk_reg(8'h00, {7'h00, irq});
      mst = 1'b1;
      wr(8'h63, 8'h00);
      chk_reg(8'h00, {7'h00, irq});
      wr(8'h63, 8'h10);
      chk_reg(8'h01, {7'h00, irq});
      wr(8'h62, 8'h10);
      chk_reg(8'h00, {7'h00, irq});
      for (i = 0; i < 4; i++)
        rdck(8'h66, {2'h0, cw[i]});
      rdck(8'h66, 8'h00);
      wr(8'h62, 8'h1F);
      fe_u.send_word(cw[5], 3, 0);
      repeat (3) step;
      rdck(8'h62, 8'h0A);
      rdck(8'h66, {2'h0, cw[5]});
      fe_u.send_word(cw[0], 3, 0);
      repeat (3) step;
      rdck(8'h61, 8'h03);
      wr(8'h60, 8'h04);
      rdck(8'h60, 8'h04);
      rdck(8'h61, 8'h09);
      rdck(8'h66, 8'h00);
      wr(8'h60, 8'h00);
      $display("rx test done");
    end
  endtask

  initial
  begin
    repeat (20) step;
    rst_i = 1'b0;
    t_regs;
    t_tx;
    t_rx;
    end_of_test;
  end
endmodule

bind fcs_feac_ctrl fcs_feac_ctrl_checker chk_u
(
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .cpu_cs_i(cpu_cs_i),
  .cpu_wr_i(cpu_wr_i), .cpu_rd_i(cpu_rd_i), .cpu_addr_i(cpu_addr_i),
  .cpu_wdata_i(cpu_wdata_i), .cpu_rdata_o(cpu_rdata_o),
  .alarm_channel_master_irq_en_i(alarm_channel_master_irq_en_i),
  .feac_irq_o(feac_irq_o), .feac_rx_bit_i(feac_rx_bit_i),
  .feac_rx_bit_en_i(feac_rx_bit_en_i),
  .feac_tx_bit_req_i(feac_tx_bit_req_i), .feac_tx_bit_o(feac_tx_bit_o)
);
